// ### common/cfg_pkg.sv
// constants, types and decode functions for the converter mode-selection block
//
// Contract
// R1 - in low-latency mode output data appears exactly ten sample-clock cycles after sampling
// R2 - reset pin held high selects parallel control from enable, clock and control pins
// R3 - parallel control configures automatically from pin levels, needing no register access
// R4 - parallel control uses enable and clock pins as multi-level analog mode inputs
// R5 - clock pin level selects coarse gain and internal or external reference
// R6 - enable pin level selects output interface type and output data format
// R7 - three control pins decoded together select power-down modes and multiplexed output
// R8 - reset pin held low turns enable, data and clock pins into a serial port
// R9 - registers are reset by pin pulse or software bit before serial programming
// R10 - serial-only use requires the host to hold all three control pins low
// R11 - reset pin low also allows serial registers and control pins together
// R12 - combined scheme configures automatically from the three control pin levels
// R13 - override bit 0 takes power-down from control pins, ignoring register bits
// R14 - override bit 1 takes power-down from register bits, overriding the pins
// R15 - control codes: normal, A off, B off, both off, down, A/B standby, mux
// R16 - falling serial clock shifts data; sixteen bits make address then data; excess dropped (count wraps: each further sixteen bits form a new word)
// R17 - software reset bit restores register defaults and then clears itself
package cfg_pkg;
  localparam int LATENCY_CYCLES = 10;
  localparam int SAMPLE_W = 12;
  localparam int SER_ADDR_W = 8;
  localparam int SER_DATA_W = 8;
  localparam int SER_WORD_W = 16;
  localparam logic [3:0] SER_CNT_LAST = 4'hF;
  localparam logic [3:0] SER_CNT_STEP = 4'h1;
  localparam logic [3:0] SER_CNT_ZERO = 4'h0;
  // serial register file
  localparam logic [7:0] SREG_RESET_ADDR = 8'h00;
  localparam logic [7:0] SREG_POWER_ADDR = 8'h01;
  localparam logic [7:0] SREG_ANALOG_ADDR = 8'h02;
  localparam logic [7:0] SREG_DEFAULT = 8'h00;
  localparam int SRESET_BIT = 0;
  localparam int PD_LSB = 0;
  localparam int PD_MSB = 2;
  localparam int PIN_OVERRIDE_BIT_BIT = 3;
  localparam int AN_GAIN_BIT = 0;
  localparam int AN_EXTREF_BIT = 1;
  localparam int AN_SBIN_BIT = 2;
  localparam int AN_CMOS_BIT = 3;
  // control pin codes, pin a is the most significant bit
  localparam logic [2:0] PD_NORMAL = 3'h0;
  localparam logic [2:0] PD_OFF_A = 3'h1;
  localparam logic [2:0] PD_OFF_B = 3'h2;
  localparam logic [2:0] PD_OFF_AB = 3'h3;
  localparam logic [2:0] PD_DOWN = 3'h4;
  localparam logic [2:0] PD_STBY_A = 3'h5;
  localparam logic [2:0] PD_STBY_B = 3'h6;
  localparam logic [2:0] PD_MUX = 3'h7;
  // quantised analog pin levels: 0, 3/8, 5/8, full supply
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_3_8 = 2'h1;
  localparam logic [1:0] LVL_5_8 = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  // register bus
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] AXI_STATUS_ADDR = 4'h0;
  localparam logic [3:0] AXI_SERIAL_ADDR = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_REFUSED_BIT = 10;
  localparam int ST_PAD_W = 21;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic {SCHEME_PARALLEL, SCHEME_SERIAL} scheme_t;

  typedef struct packed {
    logic out_off_a;
    logic out_off_b;
    logic power_down_all;
    logic standby_a;
    logic standby_b;
    logic mux_mode;
  } power_mode_t;

  function automatic power_mode_t decode_power(input logic [2:0] code);
    power_mode_t m;
    m = '0;
    case (code)
      PD_NORMAL: m = '0;
      PD_OFF_A: m.out_off_a = 1'b1;
      PD_OFF_B: m.out_off_b = 1'b1;
      PD_OFF_AB: begin
        m.out_off_a = 1'b1;
        m.out_off_b = 1'b1;
      end
      PD_DOWN: m.power_down_all = 1'b1;
      PD_STBY_A: m.standby_a = 1'b1;
      PD_STBY_B: m.standby_b = 1'b1;
      PD_MUX: m.mux_mode = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction : decode_power

  // the two middle levels share a meaning on both analog pins
  function automatic logic mid_level(input logic [1:0] lvl);
    return (lvl == LVL_3_8) || (lvl == LVL_5_8);
  endfunction : mid_level
endpackage : cfg_pkg

// ### common/serial_word_if.sv
// serial word channel between the shift receiver and the configuration core
interface serial_word_if;
  logic enable;
  logic word_valid;
  logic [7:0] word_addr;
  logic [7:0] word_data;
  modport rx (input enable, output word_valid, output word_addr, output word_data);
  modport sink (output enable, input word_valid, input word_addr, input word_data);
endinterface : serial_word_if

// ### rtl/serial_port_rx.sv
// serial port receiver: synchronises the pins and assembles 16-bit words
module serial_port_rx
  import cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_select_n,
  input wire logic serial_clk_pin,
  input wire logic serial_in_data,
  serial_word_if.rx port
);
  logic [1:0] sen_sync_reg;
  logic [1:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  logic clk_prev_reg;
  logic [SER_WORD_W-2:0] shift_reg;
  logic [3:0] cnt_reg;
  wire logic fall_edge = clk_prev_reg & ~clk_sync_reg[1];
  wire logic active = ~sen_sync_reg[1] & port.enable;
  wire logic last_bit = (cnt_reg == SER_CNT_LAST);
  wire logic [SER_WORD_W-1:0] full_word = {shift_reg, dat_sync_reg[1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sen_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      dat_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
      shift_reg <= '0;
      cnt_reg <= SER_CNT_ZERO;
      port.word_valid <= 1'b0;
      port.word_addr <= '0;
      port.word_data <= '0;
    end else begin
      sen_sync_reg <= {sen_sync_reg[0], serial_select_n};
      clk_sync_reg <= {clk_sync_reg[0], serial_clk_pin};
      dat_sync_reg <= {dat_sync_reg[0], serial_in_data};
      clk_prev_reg <= clk_sync_reg[1];
      port.word_valid <= 1'b0;
      if (!active) begin
        cnt_reg <= SER_CNT_ZERO; // R16
      end else if (fall_edge) begin
        shift_reg <= full_word[SER_WORD_W-2:0]; // R16
        cnt_reg <= cnt_reg + SER_CNT_STEP;
        if (last_bit) begin
          port.word_valid <= 1'b1; // R16
          port.word_addr <= full_word[SER_WORD_W-1:SER_DATA_W];
          port.word_data <= full_word[SER_DATA_W-1:0];
        end
      end
    end
  end

  a_word_on_sixteenth: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    port.word_valid |-> $past(fall_edge) && $past(cnt_reg) == SER_CNT_LAST && $past(active))
    else $error("serial word emitted without a sixteenth falling edge");

  a_count_dropped: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    !active ##1 !active |-> cnt_reg == SER_CNT_ZERO && !port.word_valid)
    else $error("serial bit count kept while port inactive");
endmodule : serial_port_rx

// ### rtl/adc_config_mode_select.sv
// converter mode selection: pin straps, serial registers, override and output pipeline
module adc_config_mode_select
  import cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reset_pin,
  input wire logic serial_select_n,
  input wire logic serial_clk_pin,
  input wire logic serial_in_data,
  input wire logic [1:0] sclk_level,
  input wire logic [1:0] sen_level,
  input wire logic power_mode_pin_a,
  input wire logic power_mode_pin_b,
  input wire logic power_mode_pin_c,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] sample_a_in,
  input wire logic [SAMPLE_W-1:0] sample_b_in,
  output logic data_valid_out,
  output logic [SAMPLE_W-1:0] data_a_out,
  output logic [SAMPLE_W-1:0] data_b_out,
  output logic scheme_serial,
  output logic coarse_gain_en,
  output logic ext_ref_sel,
  output logic straight_binary,
  output logic cmos_output,
  output logic out_off_a,
  output logic out_off_b,
  output logic power_down_all,
  output logic standby_a,
  output logic standby_b,
  output logic mux_mode
);
  // pin synchronisers: reset, three control pins, two analog level pairs
  logic [7:0] pin_sync1_reg;
  logic [7:0] pin_sync2_reg;
  logic [7:0] power_sreg;
  logic [7:0] analog_sreg;
  logic regs_init_reg;
  logic refused_reg;
  logic [SER_WORD_W-1:0] last_word_reg;
  scheme_t scheme_reg;
  logic [2:0] pd_code_reg;
  power_mode_t pmode_reg;
  logic gain_reg;
  logic extref_reg;
  logic sbin_reg;
  logic cmos_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [SAMPLE_W-1:0] pipe_a [LATENCY_CYCLES];
  logic [SAMPLE_W-1:0] pipe_b [LATENCY_CYCLES];
  logic [LATENCY_CYCLES-1:0] pipe_v_reg;

  serial_word_if ser ();

  serial_port_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .serial_select_n(serial_select_n),
    .serial_clk_pin(serial_clk_pin),
    .serial_in_data(serial_in_data),
    .port(ser.rx)
  );

  wire logic [7:0] pin_raw = {reset_pin, power_mode_pin_a, power_mode_pin_b, power_mode_pin_c,
                              sclk_level, sen_level};
  wire logic rst_pin_s = pin_sync2_reg[7];
  wire logic [2:0] ctrl_code = pin_sync2_reg[6:4];
  wire logic [1:0] sclk_lvl = pin_sync2_reg[3:2];
  wire logic [1:0] sen_lvl = pin_sync2_reg[1:0];
  wire logic serial_mode = !rst_pin_s; // R8 R11

  // the serial port is only live when the reset pin is low
  assign ser.enable = serial_mode; // R4

  // register bus write path
  wire logic do_write = aw_hold_reg & w_hold_reg & ~bvalid;
  wire logic wr_status = do_write && (awaddr_reg == AXI_STATUS_ADDR);
  wire logic wr_serial = do_write && (awaddr_reg == AXI_SERIAL_ADDR);
  wire logic wr_mapped = wr_status | wr_serial;

  // a word from the pins wins; a bus word in the same cycle is counted as refused
  wire logic word_take = ser.word_valid | wr_serial;
  wire logic [7:0] word_addr = ser.word_valid ? ser.word_addr
                                              : wdata_reg[SER_WORD_W-1:SER_DATA_W];
  wire logic [7:0] word_data = ser.word_valid ? ser.word_data : wdata_reg[SER_DATA_W-1:0];
  wire logic bus_lost = ser.word_valid & wr_serial;
  wire logic sw_reset = word_take && serial_mode && (word_addr == SREG_RESET_ADDR)
                        && word_data[SRESET_BIT]; // R17
  wire logic write_ok = word_take && serial_mode && regs_init_reg && !sw_reset; // R9
  wire logic refuse = (word_take && !write_ok && !sw_reset) || bus_lost;
  wire logic regs_default = rst_pin_s || sw_reset; // R9 R17

  // effective configuration
  wire logic pin_override_bit = power_sreg[PIN_OVERRIDE_BIT_BIT];
  wire logic [2:0] pd_next = (serial_mode && pin_override_bit) ? power_sreg[PD_MSB:PD_LSB] // R14
                                                   : ctrl_code; // R2 R7 R12 R13
  wire power_mode_t pmode_next = decode_power(pd_next); // R7 R15
  wire logic gain_next = serial_mode ? analog_sreg[AN_GAIN_BIT] : sclk_lvl[1]; // R5
  wire logic extref_next = serial_mode ? analog_sreg[AN_EXTREF_BIT] : mid_level(sclk_lvl); // R5
  wire logic sbin_next = serial_mode ? analog_sreg[AN_SBIN_BIT] : mid_level(sen_lvl); // R6
  wire logic cmos_next = serial_mode ? analog_sreg[AN_CMOS_BIT] : sen_lvl[1]; // R6

  wire logic [31:0] status_word = {{ST_PAD_W{1'b0}}, refused_reg, pin_override_bit, cmos_reg, sbin_reg,
                                   extref_reg, gain_reg, pd_code_reg, regs_init_reg,
                                   scheme_reg == SCHEME_SERIAL};
  wire logic [31:0] rd_word = (araddr == AXI_STATUS_ADDR) ? status_word
                            : (araddr == AXI_SERIAL_ADDR) ? {16'h0000, last_word_reg}
                            : DATA_ZERO;
  wire logic rd_mapped = (araddr == AXI_STATUS_ADDR) || (araddr == AXI_SERIAL_ADDR);

  assign awready = ~aw_hold_reg & ~bvalid;
  assign wready = ~w_hold_reg & ~bvalid;
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1_reg <= '0;
      pin_sync2_reg <= '0;
    end else begin
      pin_sync1_reg <= pin_raw;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // serial register file
  always_ff @(posedge aclk) begin
    if (!aresetn || regs_default) begin
      power_sreg <= SREG_DEFAULT; // R17
      analog_sreg <= SREG_DEFAULT;
    end else if (write_ok) begin
      if (word_addr == SREG_POWER_ADDR) power_sreg <= word_data; // R8
      if (word_addr == SREG_ANALOG_ADDR) analog_sreg <= word_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_init_reg <= 1'b0;
      refused_reg <= 1'b0;
      last_word_reg <= '0;
    end else begin
      if (regs_default) regs_init_reg <= 1'b1; // R9
      // a new refusal wins over a clear in the same cycle
      if (refuse) refused_reg <= 1'b1;
      else if (wr_status && wdata_reg[ST_REFUSED_BIT]) refused_reg <= 1'b0;
      if (write_ok) last_word_reg <= {word_addr, word_data};
    end
  end

  // configuration outputs follow pin levels continuously in parallel mode, so power-up needs no access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scheme_reg <= SCHEME_PARALLEL;
      pd_code_reg <= PD_NORMAL;
      pmode_reg <= '0;
      gain_reg <= 1'b0;
      extref_reg <= 1'b0;
      sbin_reg <= 1'b0;
      cmos_reg <= 1'b0;
    end else begin
      scheme_reg <= serial_mode ? SCHEME_SERIAL : SCHEME_PARALLEL; // R2 R8
      pd_code_reg <= pd_next; // R3 R12
      pmode_reg <= pmode_next;
      gain_reg <= gain_next;
      extref_reg <= extref_next;
      sbin_reg <= sbin_next;
      cmos_reg <= cmos_next;
    end
  end

  assign scheme_serial = (scheme_reg == SCHEME_SERIAL);
  assign coarse_gain_en = gain_reg;
  assign ext_ref_sel = extref_reg;
  assign straight_binary = sbin_reg;
  assign cmos_output = cmos_reg;
  assign out_off_a = pmode_reg.out_off_a;
  assign out_off_b = pmode_reg.out_off_b;
  assign power_down_all = pmode_reg.power_down_all;
  assign standby_a = pmode_reg.standby_a;
  assign standby_b = pmode_reg.standby_b;
  assign mux_mode = pmode_reg.mux_mode;

  // bus slave: address and data held separately, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= DATA_ZERO;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= wdata;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= DATA_ZERO;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // fixed low-latency output pipeline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe_v_reg <= '0;
    end else begin
      pipe_v_reg <= {pipe_v_reg[LATENCY_CYCLES-2:0], sample_valid_in}; // R1
    end
  end

  always_ff @(posedge aclk) begin
    pipe_a[0] <= sample_a_in;
    pipe_b[0] <= sample_b_in;
    for (int i = 1; i < LATENCY_CYCLES; i++) begin
      pipe_a[i] <= pipe_a[i-1]; // R1
      pipe_b[i] <= pipe_b[i-1];
    end
  end

  assign data_valid_out = pipe_v_reg[LATENCY_CYCLES-1];
  assign data_a_out = pipe_a[LATENCY_CYCLES-1];
  assign data_b_out = pipe_b[LATENCY_CYCLES-1];

  // helper for the checks below: cycles since reset, saturating
  logic [3:0] age_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) age_reg <= 4'h0;
    else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_latency_ten: assert property (age_reg > 4'(LATENCY_CYCLES) |-> // R1
    data_valid_out == $past(sample_valid_in, LATENCY_CYCLES)
    && data_a_out == $past(sample_a_in, LATENCY_CYCLES))
    else $error("sample did not appear ten cycles later");
  a_parallel_pins: assert property (rst_pin_s |=> // R2
    pd_code_reg == $past(ctrl_code) && !scheme_serial)
    else $error("parallel scheme ignored control pins");
  a_override_pins: assert property (serial_mode && !pin_override_bit |=> pd_code_reg == $past(ctrl_code)) // R13
    else $error("pins not in control with override clear");
  a_override_regs: assert property (serial_mode && pin_override_bit |=> // R14
    pd_code_reg == $past(power_sreg[PD_MSB:PD_LSB]))
    else $error("register bits not in control with override set");
  a_sclk_gain: assert property (!serial_mode |=> // R5
    coarse_gain_en == $past(sclk_lvl[1]) && ext_ref_sel == $past(mid_level(sclk_lvl)))
    else $error("clock pin level decoded wrongly");
  a_sen_format: assert property (!serial_mode |=> // R6
    cmos_output == $past(sen_lvl[1]) && straight_binary == $past(mid_level(sen_lvl)))
    else $error("enable pin level decoded wrongly");
  a_mux_code: assert property ((pd_code_reg == PD_MUX) == mux_mode // R15
    && (pd_code_reg == PD_DOWN) == power_down_all)
    else $error("power code decode mismatch");
  a_sw_reset: assert property (sw_reset |=> power_sreg == SREG_DEFAULT // R17
    && analog_sreg == SREG_DEFAULT && regs_init_reg)
    else $error("software reset did not restore defaults");
  a_init_gate: assert property (serial_mode && word_take && !regs_init_reg && !sw_reset |=> // R9
    $stable(power_sreg) && $stable(analog_sreg) && refused_reg)
    else $error("write accepted before register reset");
endmodule : adc_config_mode_select

// ### dv/host_port_model.sv
// host side model: reset, control and serial pins of the converter
module host_port_model (
  input wire logic aclk,
  output logic reset_pin,
  output logic serial_select_n,
  output logic serial_clk_pin,
  output logic serial_in_data,
  output logic [1:0] sclk_level,
  output logic [1:0] sen_level,
  output logic power_mode_pin_a,
  output logic power_mode_pin_b,
  output logic power_mode_pin_c
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reset_pin = 1'b0;
    serial_select_n = 1'b1;
    serial_clk_pin = 1'b1;
    serial_in_data = 1'b0;
    sclk_level = 2'h0;
    sen_level = 2'h0;
    {power_mode_pin_a, power_mode_pin_b, power_mode_pin_c} = 3'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask : hold
  task automatic set_reset(input logic level);
    @(posedge aclk);
    reset_pin <= level;
  endtask : set_reset
  task automatic set_code(input logic [2:0] code);
    @(posedge aclk);
    {power_mode_pin_a, power_mode_pin_b, power_mode_pin_c} <= code;
  endtask : set_code
  task automatic set_levels(input logic [1:0] sclk_lvl, input logic [1:0] sen_lvl);
    @(posedge aclk);
    sclk_level <= sclk_lvl;
    sen_level <= sen_lvl;
  endtask : set_levels
  // one frame, msb first; clock idles high, data line inverted once released
  task automatic send(input logic [31:0] bits, input int n);
    @(posedge aclk);
    serial_select_n <= 1'b0;
    hold(4);
    for (int i = 0; i < n; i++) begin
      serial_in_data <= bits[31 - i];
      hold(4);
      serial_clk_pin <= 1'b0;
      hold(4);
      serial_clk_pin <= 1'b1;
    end
    hold(4);
    serial_select_n <= 1'b1;
    serial_in_data <= ~bits[32 - n];
  endtask : send
endmodule : host_port_model

// ### dv/adc_config_mode_select_tb.sv
// self-checking bench for the converter mode-selection block
module adc_config_mode_select_tb import cfg_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // expected power outputs per control code, code 7 listed first
  localparam logic [7:0][5:0] PWR_TAB = {6'h01, 6'h02, 6'h04, 6'h08, 6'h30, 6'h10, 6'h20, 6'h00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, sclk_level, sen_level;
  logic [31:0] rdata;
  logic reset_pin, serial_select_n, serial_clk_pin, serial_in_data;
  logic power_mode_pin_a, power_mode_pin_b, power_mode_pin_c;
  logic sample_valid_in = 1'b0;
  logic [SAMPLE_W-1:0] sample_a_in = 12'h000;
  logic [SAMPLE_W-1:0] sample_b_in = 12'h000;
  logic data_valid_out, scheme_serial, coarse_gain_en, ext_ref_sel, straight_binary, cmos_output;
  logic [SAMPLE_W-1:0] data_a_out, data_b_out;
  logic out_off_a, out_off_b, power_down_all, standby_a, standby_b, mux_mode;
  logic [5:0] pwr;
  logic [3:0] anl;
  int n_mismatch = 0;
  int checked = 0;
  assign pwr = {out_off_a, out_off_b, power_down_all, standby_a, standby_b, mux_mode};
  assign anl = {coarse_gain_en, ext_ref_sel, straight_binary, cmos_output};
  always #12.5 aclk = ~aclk;
  adc_config_mode_select dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .reset_pin, .serial_select_n, .serial_clk_pin, .serial_in_data,
    .sclk_level, .sen_level, .power_mode_pin_a, .power_mode_pin_b, .power_mode_pin_c,
    .sample_valid_in, .sample_a_in, .sample_b_in, .data_valid_out, .data_a_out, .data_b_out,
    .scheme_serial, .coarse_gain_en, .ext_ref_sel, .straight_binary, .cmos_output, .out_off_a,
    .out_off_b, .power_down_all, .standby_a, .standby_b, .mux_mode);
  host_port_model host (.aclk, .reset_pin, .serial_select_n, .serial_clk_pin, .serial_in_data,
    .sclk_level, .sen_level, .power_mode_pin_a, .power_mode_pin_b, .power_mode_pin_c);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap, wp, ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ap && ta === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && tw === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_read
  task automatic t_reset;
    check({awready, wready, arready, bvalid, rvalid, scheme_serial, pwr}, 12'hE00);
  endtask : t_reset
  task automatic t_latency;
    @(posedge aclk);
    sample_valid_in <= 1'b1;
    sample_a_in <= 12'hA5C;
    sample_b_in <= 12'h3E1;
    @(posedge aclk);
    sample_valid_in <= 1'b0;
    sample_a_in <= 12'h000;
    sample_b_in <= 12'hFFF;
    wt(8);
    @(negedge aclk);
    check(data_valid_out, 1'b0);
    @(negedge aclk);
    check({data_valid_out, data_a_out, data_b_out}, {1'b1, 12'hA5C, 12'h3E1});
    @(negedge aclk);
    check(data_valid_out, 1'b0);
  endtask : t_latency
  task automatic t_serial;
    logic [31:0] d;
    logic [1:0] r;
    wt(8);
    check(scheme_serial, 1'b1);
    host.send({16'h010C, 16'h0000}, 16);
    wt(12);
    axi_read(AXI_STATUS_ADDR, d, r);
    check({d[10], d[1], pwr}, {2'b10, 6'h00});
    axi_write(AXI_STATUS_ADDR, 32'h0000_0400, r);
    host.send({16'h0001, 16'h0000}, 16);
    wt(12);
    axi_read(AXI_STATUS_ADDR, d, r);
    check({d[10], d[1]}, 2'b01);
    host.send({16'h010C, 16'h0000}, 16);
    wt(12);
    check(pwr, PWR_TAB[4]);
    host.set_code(3'h5);
    wt(8);
    check(pwr, PWR_TAB[4]);
    host.send({16'h0104, 16'h0000}, 16);
    wt(12);
    check(pwr, PWR_TAB[5]);
    host.send({16'h020F, 16'hF800}, 21);
    wt(12);
    check(anl, 4'hF);
    host.send({16'h0205, 16'h0000}, 16);
    wt(12);
    check(anl, 4'hA);
    axi_write(AXI_SERIAL_ADDR, 32'h0000_020A, r);
    check(r, RESP_OKAY);
    wt(4);
    check(anl, 4'h5);
    axi_read(AXI_SERIAL_ADDR, d, r);
    check(d[15:0], 16'h020A);
    axi_read(4'h8, d, r);
    check(r, RESP_SLVERR);
    axi_write(4'hC, 32'h0000_0104, r);
    check(r, RESP_SLVERR);
    host.send({16'h0001, 16'h0000}, 16);
    wt(12);
    check({anl, pwr}, {4'h0, PWR_TAB[5]});
    host.set_code(3'h0);
  endtask : t_serial
  task automatic t_parallel;
    logic [1:0] lv;
    logic [31:0] d;
    logic [1:0] r;
    host.set_reset(1'b1);
    wt(8);
    check(scheme_serial, 1'b0);
    for (int c = 0; c < 8; c++) begin
      host.set_code(3'(c));
      wt(8);
      check(pwr, PWR_TAB[c]);
    end
    for (int l = 0; l < 4; l++) begin
      lv = 2'(l);
      host.set_levels(lv, lv);
      wt(8);
      check(anl, {lv[1], lv[0] ^ lv[1], lv[0] ^ lv[1], lv[1]});
    end
    host.send({16'h010C, 16'h0000}, 16);
    wt(12);
    check(pwr, PWR_TAB[7]);
    axi_read(AXI_STATUS_ADDR, d, r);
    check(r, RESP_OKAY);
    check({d[10], d[0]}, 2'b00);
  endtask : t_parallel
  initial begin
    #500000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    wt(6);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset;
    t_latency;
    t_serial;
    t_parallel;
    complete_run;
  end
endmodule : adc_config_mode_select_tb
